// ==== hdl/pmfp_pkg.sv ====
// Purpose: shared constants and carriers of the fabric-side master port of the PCI core
// Assumes: one clock, fabric side; the PCI clock arrives as a sampled rising-edge pulse
// Notes: the list below states the behaviour this port keeps
//
// Behaviour
// - The core presents a 64-bit data bus and an 8-bit extension from its read path.
// - The core raises an active-high abort flag when its current PCI cycle is aborted.
// - With shift select at 1 the status output is the OR of all masked status bits.
// - With shift select at 0 the status output walks all status bits, mask ignored, one per PCI edge.
// - Returning shift select to 1 restarts the serial walk from the first bit.
// - The status set holds parity error, target abort received and master abort received.
// - Each clock edge with address load low, no FIFO clear and the address store not full captures command, burst length and address.
// - The core drives an active-low full flag when no further address can be taken.
// - The core exposes a 3-bit state counter tracking master read and write progress.
// - An active-low master FIFO clear from the fabric empties every master FIFO.
// - The master-ready output is low from one clock after PCI bus reset or a FIFO clear starts until one clock after it ends.
package pmfp_pkg;

    localparam int DATA_W = 64;
    localparam int EXT_W = 8;
    localparam int CMD_W = 4;
    localparam int BURST_W = 8;
    localparam int ADDR_W = 64;
    localparam int STATE_W = 3;
    localparam int FIFO_DEPTH = 16;
    localparam int ADDR_DEPTH = 2;

    // status bit positions
    localparam int NUM_STAT = 3;
    localparam int STAT_PARITY = 0;
    localparam int STAT_TABORT = 1;
    localparam int STAT_MABORT = 2;

    // command bit that marks a write in the PCI command code
    localparam int CMD_WRITE_BIT = 0;

    // state counter codes seen by the fabric
    localparam logic [STATE_W-1:0] SC_IDLE = 3'h0;
    localparam logic [STATE_W-1:0] SC_ADDR = 3'h1;
    localparam logic [STATE_W-1:0] SC_WDATA = 3'h2;
    localparam logic [STATE_W-1:0] SC_RDATA = 3'h3;
    localparam logic [STATE_W-1:0] SC_DONE = 3'h4;

    typedef struct packed {
        logic [EXT_W-1:0] ext;
        logic [DATA_W-1:0] main;
    } pmfp_data_t;

    typedef struct packed {
        logic [CMD_W-1:0] cmd;
        logic [BURST_W-1:0] burst;
        logic [ADDR_W-1:0] addr;
    } pmfp_addr_t;

endpackage

// ==== hdl/pmfp_fifo.sv ====
// Purpose: small synchronous FIFO with valid/ready on both sides and a flush
// Assumes: flush empties the store in one cycle and wins over a push
// Notes: storage is flip-flops indexed by read and write pointers
module pmfp_fifo #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic flush_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin
        $error("pmfp_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != (PW+1)'(DEPTH)) && !flush_i;
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i && !flush_i;

    always_ff @(posedge clk_sys_i)
    begin
        if (push)
            mem_q[wr_q] <= in_data_i;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else if (flush_i)
        begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end

endmodule

// ==== hdl/pmfp_port.sv ====
// Purpose: fabric-facing master port of the embedded PCI core
// Assumes: fabric inputs are synchronous to clk_sys_i; pci_clk_rise_i marks PCI rising edges
// Notes: the PCI-side engine is reduced to valid/ready and acknowledge strobes
module pmfp_port #(
    parameter int FIFO_DEPTH = pmfp_pkg::FIFO_DEPTH,
    parameter int ADDR_DEPTH = pmfp_pkg::ADDR_DEPTH
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // data from fabric into the master write FIFO
    input wire pmfp_pkg::pmfp_data_t fab_wdata_i,
    input wire logic fab_wvalid_i,
    output logic fab_wready_o,
    // data to fabric from the master read path
    output pmfp_pkg::pmfp_data_t fab_rdata_o,
    output logic fab_rvalid_o,
    // master general signals
    input wire logic fabric_master_busy_n_i,
    output logic cycle_aborted_o,
    input wire logic status_shift_sel_i,
    input wire logic [pmfp_pkg::NUM_STAT-1:0] status_mask_i,
    output logic status_o,
    // master address loading
    input wire logic addr_load_n_i,
    input wire logic [pmfp_pkg::CMD_W-1:0] cmd_i,
    input wire logic [pmfp_pkg::BURST_W-1:0] burst_len_i,
    input wire logic [pmfp_pkg::ADDR_W-1:0] start_addr_i,
    output logic master_addr_full_n_o,
    output logic [pmfp_pkg::STATE_W-1:0] master_state_o,
    input wire logic master_fifo_clear_n_i,
    output logic master_ready_o,
    // PCI-side engine
    input wire logic pci_clk_rise_i,
    input wire logic pci_bus_reset_i,
    output pmfp_pkg::pmfp_addr_t pci_addr_o,
    output logic pci_addr_valid_o,
    input wire logic pci_addr_ack_i,
    output pmfp_pkg::pmfp_data_t pci_wdata_o,
    output logic pci_wvalid_o,
    input wire logic pci_wready_i,
    input wire pmfp_pkg::pmfp_data_t pci_rdata_i,
    input wire logic pci_rvalid_i,
    input wire logic pci_abort_i,
    input wire logic pci_parity_err_i,
    input wire logic pci_target_abort_i,
    input wire logic pci_master_abort_i
);

    localparam int AW = $clog2(ADDR_DEPTH);
    localparam int DW = $bits(pmfp_pkg::pmfp_data_t);

    if (ADDR_DEPTH < 2 || (ADDR_DEPTH & (ADDR_DEPTH - 1)) != 0)
    begin
        $error("pmfp_port: ADDR_DEPTH must be a power of two, at least 2");
    end
    if (FIFO_DEPTH < 2)
    begin
        $error("pmfp_port: FIFO_DEPTH must be at least 2");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_WDATA,
        ST_RDATA,
        ST_DONE
    } pmfp_state_t;

    // declared early: the write FIFO and address store both gate on it
    pmfp_state_t state_q;

    ////////////////////////////////////////////////////////////////////////////////
    // clear and ready

    logic clear;
    logic ready_q;

    // clear is level-sensitive: every master store stays empty while it is held
    assign clear = !master_fifo_clear_n_i;

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            ready_q <= 1'b0;
        else
            ready_q <= !pci_bus_reset_i && !clear;
    end

    assign master_ready_o = ready_q;

    ////////////////////////////////////////////////////////////////////////////////
    // master write FIFO

    // fabric busy input carries no function in this core
    logic busy_unused;
    assign busy_unused = fabric_master_busy_n_i;

    pmfp_fifo #(
        .WIDTH(DW),
        .DEPTH(FIFO_DEPTH)
    ) u_wfifo (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .flush_i(clear),
        .in_valid_i(fab_wvalid_i),
        .in_ready_o(fab_wready_o),
        .in_data_i(fab_wdata_i),
        .out_valid_o(pci_wvalid_o),
        .out_ready_i(pci_wready_i && (state_q == ST_WDATA)),
        .out_data_o(pci_wdata_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // master address register

    pmfp_pkg::pmfp_addr_t aq_q [ADDR_DEPTH];
    logic [AW-1:0] aw_q;
    logic [AW-1:0] ar_q;
    logic [AW:0] acnt_q;
    logic a_full;
    logic a_push;
    logic a_pop;

    assign a_full = (acnt_q == (AW+1)'(ADDR_DEPTH));
    // a load while full is dropped; fabric is expected to watch the flag
    assign a_push = !addr_load_n_i && !a_full && !clear;
    assign a_pop = pci_addr_valid_o && pci_addr_ack_i && (state_q == ST_ADDR);
    assign master_addr_full_n_o = !a_full;
    assign pci_addr_valid_o = (acnt_q != '0) && (state_q == ST_ADDR);
    assign pci_addr_o = aq_q[ar_q];

    always_ff @(posedge clk_sys_i)
    begin
        if (a_push)
        begin
            aq_q[aw_q].cmd <= cmd_i;
            aq_q[aw_q].burst <= burst_len_i;
            aq_q[aw_q].addr <= start_addr_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            aw_q <= '0;
            ar_q <= '0;
            acnt_q <= '0;
        end
        else if (clear)
        begin
            aw_q <= '0;
            ar_q <= '0;
            acnt_q <= '0;
        end
        else
        begin
            if (a_push)
                aw_q <= aw_q + 1'b1;
            if (a_pop)
                ar_q <= ar_q + 1'b1;
            if (a_push && !a_pop)
                acnt_q <= acnt_q + 1'b1;
            else if (a_pop && !a_push)
                acnt_q <= acnt_q - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // master engine and state counter

    logic [pmfp_pkg::BURST_W-1:0] beats_q;
    logic beat;
    logic last_beat;

    assign beat = ((state_q == ST_WDATA) && pci_wvalid_o && pci_wready_i)
        || ((state_q == ST_RDATA) && pci_rvalid_i);
    // a burst length of zero is served as one beat
    assign last_beat = beat && (beats_q <= 8'h01);

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= ST_IDLE;
            beats_q <= '0;
        end
        else if (clear || pci_bus_reset_i)
        begin
            state_q <= ST_IDLE;
            beats_q <= '0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (acnt_q != '0)
                        state_q <= ST_ADDR;
                end
                ST_ADDR:
                begin
                    if (a_pop)
                    begin
                        beats_q <= pci_addr_o.burst;
                        if (pci_addr_o.cmd[pmfp_pkg::CMD_WRITE_BIT])
                            state_q <= ST_WDATA;
                        else
                            state_q <= ST_RDATA;
                    end
                end
                ST_WDATA, ST_RDATA:
                begin
                    if (pci_abort_i || last_beat)
                        state_q <= ST_DONE;
                    else if (beat)
                        beats_q <= beats_q - 1'b1;
                end
                ST_DONE:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    always_comb
    begin
        master_state_o = pmfp_pkg::SC_IDLE;
        unique case (state_q)
            ST_IDLE: master_state_o = pmfp_pkg::SC_IDLE;
            ST_ADDR: master_state_o = pmfp_pkg::SC_ADDR;
            ST_WDATA: master_state_o = pmfp_pkg::SC_WDATA;
            ST_RDATA: master_state_o = pmfp_pkg::SC_RDATA;
            ST_DONE: master_state_o = pmfp_pkg::SC_DONE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data to fabric

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            fab_rdata_o <= '0;
            fab_rvalid_o <= 1'b0;
        end
        else if (clear)
            fab_rvalid_o <= 1'b0;
        else
        begin
            fab_rvalid_o <= (state_q == ST_RDATA) && pci_rvalid_i;
            if ((state_q == ST_RDATA) && pci_rvalid_i)
                fab_rdata_o <= pci_rdata_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // abort indication

    // held from the abort until the next address is acknowledged or a FIFO clear
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cycle_aborted_o <= 1'b0;
        else if (pci_abort_i && (state_q == ST_WDATA || state_q == ST_RDATA))
            cycle_aborted_o <= 1'b1;
        else if (a_pop || clear)
            cycle_aborted_o <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status flags and status output

    logic [pmfp_pkg::NUM_STAT-1:0] stat_q;
    logic [pmfp_pkg::NUM_STAT-1:0] stat_set;
    logic [1:0] sidx_q;
    logic status_q;

    always_comb
    begin
        stat_set = '0;
        stat_set[pmfp_pkg::STAT_PARITY] = pci_parity_err_i;
        stat_set[pmfp_pkg::STAT_TABORT] = pci_target_abort_i;
        stat_set[pmfp_pkg::STAT_MABORT] = pci_master_abort_i;
    end

    // sticky; a bus reset clears them, but a new event in the same cycle wins
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            stat_q <= '0;
        else if (pci_bus_reset_i)
            stat_q <= stat_set;
        else
            stat_q <= stat_q | stat_set;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sidx_q <= '0;
        else if (status_shift_sel_i)
            sidx_q <= '0;
        else if (pci_clk_rise_i)
        begin
            if (sidx_q == 2'(pmfp_pkg::NUM_STAT - 1))
                sidx_q <= '0;
            else
                sidx_q <= sidx_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            status_q <= 1'b0;
        else if (status_shift_sel_i)
            status_q <= |(stat_q & status_mask_i);
        else
            status_q <= stat_q[sidx_q];
    end

    assign status_o = status_q;

endmodule

// ==== testbench/pmfp_port_props.sv ====
// Purpose: concurrent checks on the ports of the fabric-side master port
// Assumes: single clock domain, async active-low reset
// Notes: bound to pmfp_port from the testbench top file
module pmfp_port_props (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // watched ports
    input wire logic addr_load_n_i,
    input wire logic master_addr_full_n_o,
    input wire logic pci_addr_ack_i,
    input wire logic pci_addr_valid_o,
    input wire logic master_fifo_clear_n_i,
    input wire logic master_ready_o,
    input wire logic pci_bus_reset_i,
    input wire logic [pmfp_pkg::STATE_W-1:0] master_state_o,
    input wire logic pci_rvalid_i,
    input wire pmfp_pkg::pmfp_data_t pci_rdata_i,
    input wire logic fab_rvalid_o,
    input wire pmfp_pkg::pmfp_data_t fab_rdata_o,
    input wire logic fab_wready_o,
    input wire logic pci_abort_i,
    input wire logic cycle_aborted_o,
    input wire logic status_shift_sel_i,
    input wire logic [pmfp_pkg::NUM_STAT-1:0] status_mask_i,
    input wire logic status_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);
    logic clr_n;
    assign clr_n = master_fifo_clear_n_i;
    ////////////////////////////////////////////////////////////////////////
    full_hold_a: assert property (!master_addr_full_n_o && !pci_addr_ack_i && clr_n
        |=> !master_addr_full_n_o) else $error("full flag dropped without an ack");
    load_state_a: assert property (!addr_load_n_i && master_addr_full_n_o && clr_n
        && master_state_o == pmfp_pkg::SC_IDLE |-> ##[1:2] master_state_o == pmfp_pkg::SC_ADDR)
        else $error("load did not start an address phase");
    addr_valid_a: assert property (master_state_o == pmfp_pkg::SC_ADDR |-> pci_addr_valid_o)
        else $error("address phase without valid address");
    ready_clear_a: assert property (!clr_n |=> !master_ready_o)
        else $error("ready high after a clear");
    ready_busrst_a: assert property (pci_bus_reset_i |=> !master_ready_o)
        else $error("ready high after a bus reset");
    wready_clear_a: assert property (!clr_n |-> !fab_wready_o)
        else $error("write FIFO accepts during clear");
    rdata_pass_a: assert property (master_state_o == pmfp_pkg::SC_RDATA && pci_rvalid_i && clr_n
        |=> fab_rvalid_o && fab_rdata_o == $past(pci_rdata_i)) else $error("read word lost");
    abort_set_a: assert property (pci_abort_i && clr_n && master_state_o inside {3'h2, 3'h3}
        |=> cycle_aborted_o) else $error("abort not flagged");
    mask_zero_a: assert property (status_shift_sel_i && status_mask_i == 3'h0 |=> !status_o)
        else $error("masked status still reported");
    full_c: cover property (!master_addr_full_n_o);
    wdata_c: cover property (master_state_o == pmfp_pkg::SC_WDATA);
    abort_c: cover property (cycle_aborted_o);
endmodule

// ==== testbench/pmfp_fab_model.sv ====
// Purpose: fabric user logic pushing a numbered run of words into the write FIFO
// Assumes: word n is {n, 5a5a.. | n}; released data lines show the inverted word
// Notes: holds each word until the port takes it, so nothing is lost on stalls
module pmfp_fab_model (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // control from the bench
    input wire logic start_i,
    input wire logic [4:0] count_i,
    // towards the port
    input wire logic ready_i,
    output pmfp_pkg::pmfp_data_t wdata_o,
    output logic wvalid_o,
    output logic busy_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] left_q;
    logic [7:0] seq_q;
    pmfp_pkg::pmfp_data_t word;
    assign busy_n_o = 1'b1;
    assign word = {seq_q, 64'h5a5a_0000_0000_0000 | 64'(seq_q)};
    assign wvalid_o = (left_q != 5'h0);
    assign wdata_o = wvalid_o ? word : ~word;
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            left_q <= 5'h0;
            seq_q <= 8'h0;
        end
        else if (start_i)
        begin
            left_q <= count_i;
            seq_q <= 8'h0;
        end
        else if (wvalid_o && ready_i)
        begin
            left_q <= left_q - 5'h1;
            seq_q <= seq_q + 8'h1;
        end
    end
endmodule

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench of the fabric-side master port
// Assumes: inputs change at the falling edge; PCI engine side driven here
// Notes: write data comes from the fabric model
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, fab_start = 1'b0, fab_wvalid_i, fabric_master_busy_n_i;
    logic [4:0] fab_count = 5'h0;
    pmfp_pkg::pmfp_data_t fab_wdata_i, fab_rdata_o, pci_wdata_o, pci_rdata_i = '1;
    pmfp_pkg::pmfp_addr_t pci_addr_o;
    logic fab_wready_o, fab_rvalid_o, cycle_aborted_o, status_o, master_addr_full_n_o;
    logic master_ready_o, pci_addr_valid_o, pci_wvalid_o;
    logic [2:0] master_state_o, status_mask_i = 3'h7;
    logic status_shift_sel_i = 1'b1, addr_load_n_i = 1'b1, master_fifo_clear_n_i = 1'b1;
    logic [3:0] cmd_i = 4'h0;
    logic [7:0] burst_len_i = 8'h0;
    logic [63:0] start_addr_i = 64'h0;
    logic pci_clk_rise_i = 0, pci_bus_reset_i = 0, pci_addr_ack_i = 0, pci_wready_i = 0;
    logic pci_rvalid_i = 0, pci_abort_i = 0, pci_parity_err_i = 0;
    logic pci_target_abort_i = 0, pci_master_abort_i = 0;
    int bad_count = 0, n_checks = 0;
    pmfp_port i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .fab_wdata_i(fab_wdata_i),
        .fab_wvalid_i(fab_wvalid_i), .fab_wready_o(fab_wready_o), .fab_rdata_o(fab_rdata_o),
        .fab_rvalid_o(fab_rvalid_o), .fabric_master_busy_n_i(fabric_master_busy_n_i),
        .cycle_aborted_o(cycle_aborted_o), .status_shift_sel_i(status_shift_sel_i),
        .status_mask_i(status_mask_i), .status_o(status_o), .addr_load_n_i(addr_load_n_i),
        .cmd_i(cmd_i), .burst_len_i(burst_len_i), .start_addr_i(start_addr_i),
        .master_addr_full_n_o(master_addr_full_n_o), .master_state_o(master_state_o),
        .master_fifo_clear_n_i(master_fifo_clear_n_i), .master_ready_o(master_ready_o),
        .pci_clk_rise_i(pci_clk_rise_i), .pci_bus_reset_i(pci_bus_reset_i),
        .pci_addr_o(pci_addr_o), .pci_addr_valid_o(pci_addr_valid_o),
        .pci_addr_ack_i(pci_addr_ack_i), .pci_wdata_o(pci_wdata_o), .pci_wvalid_o(pci_wvalid_o),
        .pci_wready_i(pci_wready_i), .pci_rdata_i(pci_rdata_i), .pci_rvalid_i(pci_rvalid_i),
        .pci_abort_i(pci_abort_i), .pci_parity_err_i(pci_parity_err_i),
        .pci_target_abort_i(pci_target_abort_i), .pci_master_abort_i(pci_master_abort_i));
    pmfp_fab_model i_fab (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .start_i(fab_start),
        .count_i(fab_count), .ready_i(fab_wready_o), .wdata_o(fab_wdata_i),
        .wvalid_o(fab_wvalid_i), .busy_n_o(fabric_master_busy_n_i));
    initial forever #2.5 clk_sys_i = ~clk_sys_i;
    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
    endtask
    task automatic wait_st(input logic [2:0] s);
        for (int i = 0; i < 40 && master_state_o !== s; i++) tick(1);
        `CHK("state", s, master_state_o)
    endtask
    task automatic load(input logic [3:0] c, input logic [7:0] b, input logic [63:0] a);
        addr_load_n_i = 1'b0;
        {cmd_i, burst_len_i, start_addr_i} = {c, b, a};
        tick(1);
        addr_load_n_i = 1'b1;
        tick(1);
    endtask
    task automatic fab_run(input logic [4:0] n);
        fab_count = n;
        pulse(fab_start);
    endtask
    task automatic t_addr_write();
        int k = 0;
        fab_run(5'd17);
        load(4'h7, 8'd17, 64'h1000_0000);
        load(4'h6, 8'd3, 64'h2000_0040);
        `CHK("full_n", 1'b0, master_addr_full_n_o)
        tick(20);
        `CHK("wready", 1'b0, fab_wready_o)
        `CHK("addr", {4'h7, 8'd17, 64'h1000_0000}, pci_addr_o)
        wait_st(pmfp_pkg::SC_ADDR);
        pulse(pci_addr_ack_i);
        `CHK("full_n", 1'b1, master_addr_full_n_o)
        wait_st(pmfp_pkg::SC_WDATA);
        for (int i = 0; i < 100 && k < 17; i++)
        begin
            pci_wready_i = i[0];
            #1;
            if (pci_wvalid_o && pci_wready_i)
            begin
                `CHK("wdata", {8'(k), 64'h5a5a_0000_0000_0000 | 64'(k)}, pci_wdata_o)
                k++;
            end
            tick(1);
        end
        pci_wready_i = 1'b0;
        wait_st(pmfp_pkg::SC_DONE);
        wait_st(pmfp_pkg::SC_ADDR);
        `CHK("addr", {4'h6, 8'd3, 64'h2000_0040}, pci_addr_o)
        $display("test addr_write done");
    endtask
    task automatic t_read_abort();
        pulse(pci_addr_ack_i);
        wait_st(pmfp_pkg::SC_RDATA);
        pci_rdata_i = {8'hc3, 64'h0123_4567_89ab_cdef};
        pulse(pci_rvalid_i);
        pci_rdata_i = ~pci_rdata_i;
        `CHK("rvalid", 1'b1, fab_rvalid_o)
        `CHK("rdata", {8'hc3, 64'h0123_4567_89ab_cdef}, fab_rdata_o)
        pulse(pci_abort_i);
        `CHK("aborted", 1'b1, cycle_aborted_o)
        wait_st(pmfp_pkg::SC_IDLE);
        $display("test read_abort done");
    endtask
    task automatic t_status();
        pulse(pci_bus_reset_i);
        `CHK("ready", 1'b0, master_ready_o)
        pulse(pci_parity_err_i);
        pulse(pci_master_abort_i);
        for (int m = 0; m < 8; m++)
        begin
            status_mask_i = 3'(m);
            tick(2);
            `CHK("status_or", |(3'(m) & 3'h5), status_o)
        end
        status_mask_i = 3'h0;
        status_shift_sel_i = 1'b0;
        tick(2);
        `CHK("bit0", 1'b1, status_o)
        for (int b = 1; b < 5; b++)
        begin
            pulse(pci_clk_rise_i);
            tick(1);
            `CHK("bit", (3'h5 >> (b % 3)) & 3'h1, 3'(status_o))
        end
        status_shift_sel_i = 1'b1;
        tick(2);
        status_shift_sel_i = 1'b0;
        tick(2);
        `CHK("restart", 1'b1, status_o)
        status_shift_sel_i = 1'b1;
        pulse(pci_target_abort_i);
        status_mask_i = 3'h2;
        tick(2);
        `CHK("tabort", 1'b1, status_o)
        $display("test status done");
    endtask
    task automatic t_clear();
        fab_run(5'd4);
        tick(8);
        load(4'h7, 8'd4, 64'h3000_0000);
        master_fifo_clear_n_i = 1'b0;
        tick(1);
        `CHK("wready", 1'b0, fab_wready_o)
        `CHK("ready", 1'b0, master_ready_o)
        master_fifo_clear_n_i = 1'b1;
        tick(2);
        `CHK("wvalid", 1'b0, pci_wvalid_o)
        `CHK("state", pmfp_pkg::SC_IDLE, master_state_o)
        `CHK("ready", 1'b1, master_ready_o)
        `CHK("aborted", 1'b0, cycle_aborted_o)
        $display("test clear done");
    endtask
    task automatic t_reset();
        tick(3);
        `CHK("full_n", 1'b1, master_addr_full_n_o)
        rst_n_i = 1'b1;
        tick(2);
        `CHK("ready", 1'b1, master_ready_o)
        $display("test reset done");
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        t_reset();
        t_addr_write();
        t_read_abort();
        t_status();
        t_clear();
        print_verdict();
    end
    initial
    begin
        #20us;
        bad_count++;
        print_verdict();
    end
endmodule
bind pmfp_port pmfp_port_props i_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .addr_load_n_i(addr_load_n_i), .master_addr_full_n_o(master_addr_full_n_o),
    .pci_addr_ack_i(pci_addr_ack_i), .pci_addr_valid_o(pci_addr_valid_o),
    .master_fifo_clear_n_i(master_fifo_clear_n_i), .master_ready_o(master_ready_o),
    .pci_bus_reset_i(pci_bus_reset_i), .master_state_o(master_state_o),
    .pci_rvalid_i(pci_rvalid_i), .pci_rdata_i(pci_rdata_i), .fab_rvalid_o(fab_rvalid_o),
    .fab_rdata_o(fab_rdata_o), .fab_wready_o(fab_wready_o), .pci_abort_i(pci_abort_i),
    .cycle_aborted_o(cycle_aborted_o), .status_shift_sel_i(status_shift_sel_i),
    .status_mask_i(status_mask_i), .status_o(status_o));
